//--- rtl/gpm_out_mux.sv
// Source group and signal selection for one pin
`timescale 1ns/1ns
`default_nettype none
module gpm_out_mux
    import gpm_pkg::*;
(
    input  wire logic [2:0]            src,
    input  wire logic [2:0]            sel,
    input  wire logic                  sw_value,
    input  wire logic [RX_PORTS*4-1:0] rx_remote_gpio,
    input  wire logic [RX_PORTS-1:0]   rx_lock,
    input  wire logic [RX_PORTS-1:0]   rx_pass,
    input  wire logic [RX_PORTS-1:0]   rx_frame_valid,
    input  wire logic [RX_PORTS-1:0]   rx_line_valid,
    input  wire logic [RX_PORTS-1:0]   rx_port_enable,
    input  wire logic                  frame_sync_pulse,
    input  wire logic [TX_PORTS*4-1:0] tx_rx_select,
    input  wire logic [TX_PORTS-1:0]   tx_frame_valid,
    input  wire logic [TX_PORTS-1:0]   tx_line_valid,
    input  wire logic [TX_PORTS-1:0]   tx_synchronized,
    input  wire logic [TX_PORTS-1:0]   tx_interrupt,
    output logic                       level
);

    logic [1:0]          rx_idx;
    logic                tx_idx;
    logic [3:0]          rx_gpio4;
    logic [RX_PORTS-1:0] tx_sel_ports;
    logic [7:0]          rx_group;
    logic [7:0]          dev_group;
    logic [7:0]          tx_group;
    logic                is_rx;
    logic                is_dev;
    logic                is_tx;

    assign rx_idx = src[1:0];
    assign tx_idx = src[0];
    assign is_rx  = !src[2];
    assign is_dev = (src == SRC_DEVICE);
    assign is_tx  = (src == SRC_TX0) || (src == SRC_TX1);

    assign rx_gpio4 = rx_remote_gpio[{rx_idx, 2'b00} +: 4];
    assign rx_group[3:0] = rx_gpio4;
    assign rx_group[SEL_RX_LOCK]  = rx_lock[rx_idx];
    assign rx_group[SEL_RX_PASS]  = rx_pass[rx_idx];
    assign rx_group[SEL_RX_FRAME] = rx_frame_valid[rx_idx];
    assign rx_group[SEL_RX_LINE]  = rx_line_valid[rx_idx];

    assign dev_group[SEL_DEV_SW] = sw_value;
    assign dev_group[SEL_DEV_LOCK_OR] = |(rx_lock & rx_port_enable);
    assign dev_group[SEL_DEV_PASS_AND] = (|rx_port_enable) && (&(rx_pass | ~rx_port_enable));
    assign dev_group[SEL_DEV_FRAME_SYNC] = frame_sync_pulse;
    assign dev_group[7:4] = 4'h0;

    assign tx_sel_ports = tx_rx_select[{tx_idx, 2'b00} +: 4];
    assign tx_group[SEL_TX_PASS_AND] = (|tx_sel_ports) && (&(rx_pass | ~tx_sel_ports));
    assign tx_group[SEL_TX_PASS_OR]  = |(rx_pass & tx_sel_ports);
    assign tx_group[SEL_TX_FRAME] = tx_frame_valid[tx_idx];
    assign tx_group[SEL_TX_LINE]  = tx_line_valid[tx_idx];
    assign tx_group[SEL_TX_SYNC]  = tx_synchronized[tx_idx];
    assign tx_group[SEL_TX_IRQ]   = tx_interrupt[tx_idx];
    assign tx_group[7:6] = 2'h0;

    // Select within group, reserved group low
    assign level = is_rx  ? rx_group[sel]  :
                   is_dev ? dev_group[sel] :
                   is_tx  ? tx_group[sel]  : 1'b0;

endmodule : gpm_out_mux
`default_nettype wire

//--- rtl/gpm_pin_ctrl.sv
// AXI4-Lite register block and output control for two general-purpose pins
// Notes on behaviour
// - Bits 4:2 pick receive, status or transmit group
// - Bits 7:5 pick signal within that group
// - Receive group codes 0-3 give remote signals
// - Receive group 4 lock, 5 pass
// - Receive group 6 frame valid, 7 line
// - Status group 0 gives software value
// - Status group 1 ORs enabled port locks
// - Status group 2 ANDs enabled port passes
// - Status group routes frame sync pulse
// - Status group codes 4 to 7 reserved
// - Transmit group 0 AND, 1 OR pass
// - Transmit group 2 frame, 3 line sending
// - Transmit group 4 multi-port synchronized
// - Transmit group 5 interrupt, 6 and 7 reserved
// - Bit 1 is the software output value
// - Bit 0 enables the pin driver
// - Control register at 0x11, resets zero
// - Input enable per pin, resets enabled
`timescale 1ns/1ns
`default_nettype none
module gpm_pin_ctrl
    import gpm_pkg::*;
(
    input  wire logic                  aclk,
    input  wire logic                  aresetn,
    input  wire logic [ADDR_W-1:0]     s_axi_awaddr,
    input  wire logic [2:0]            s_axi_awprot,
    input  wire logic                  s_axi_awvalid,
    output logic                       s_axi_awready,
    input  wire logic [DATA_W-1:0]     s_axi_wdata,
    input  wire logic [3:0]            s_axi_wstrb,
    input  wire logic                  s_axi_wvalid,
    output logic                       s_axi_wready,
    output logic [1:0]                 s_axi_bresp,
    output logic                       s_axi_bvalid,
    input  wire logic                  s_axi_bready,
    input  wire logic [ADDR_W-1:0]     s_axi_araddr,
    input  wire logic [2:0]            s_axi_arprot,
    input  wire logic                  s_axi_arvalid,
    output logic                       s_axi_arready,
    output logic [DATA_W-1:0]          s_axi_rdata,
    output logic [1:0]                 s_axi_rresp,
    output logic                       s_axi_rvalid,
    input  wire logic                  s_axi_rready,
    input  wire logic [RX_PORTS*4-1:0] rx_remote_gpio,
    input  wire logic [RX_PORTS-1:0]   rx_lock,
    input  wire logic [RX_PORTS-1:0]   rx_pass,
    input  wire logic [RX_PORTS-1:0]   rx_frame_valid,
    input  wire logic [RX_PORTS-1:0]   rx_line_valid,
    input  wire logic [RX_PORTS-1:0]   rx_port_enable,
    input  wire logic                  frame_sync_pulse,
    input  wire logic [TX_PORTS*4-1:0] tx_rx_select,
    input  wire logic [TX_PORTS-1:0]   tx_frame_valid,
    input  wire logic [TX_PORTS-1:0]   tx_line_valid,
    input  wire logic [TX_PORTS-1:0]   tx_synchronized,
    input  wire logic [TX_PORTS-1:0]   tx_interrupt,
    input  wire logic [PIN_COUNT-1:0]  pin_in,
    output logic      [PIN_COUNT-1:0]  pin_out,
    output logic      [PIN_COUNT-1:0]  pin_oe,
    output logic      [PIN_COUNT-1:0]  pin_input_data
);

    // Register index decode from a byte address
    function automatic gpm_reg_e decode_reg(input logic [ADDR_W-1:0] a);
        gpm_reg_e r;
        r = REG_NONE;
        if (a[ADDR_W-1:2] == IDX_PIN1_CTL[ADDR_W-3:0]) begin
            r = REG_PIN1;
        end else if (a[ADDR_W-1:2] == IDX_PIN2_CTL[ADDR_W-3:0]) begin
            r = REG_PIN2;
        end else if (a[ADDR_W-1:2] == IDX_INPUT_EN[ADDR_W-3:0]) begin
            r = REG_INEN;
        end else if (a[ADDR_W-1:2] == IDX_PIN_STATUS[ADDR_W-3:0]) begin
            r = REG_STATUS;
        end
        return r;
    endfunction : decode_reg

    logic [CTL_W-1:0]     ctl [PIN_COUNT];
    logic [PIN_COUNT-1:0] pin_input_enable;
    logic [PIN_COUNT-1:0] pin_in_sync;
    logic [PIN_COUNT-1:0] mux_level;

    logic                 aw_held;
    logic [ADDR_W-1:0]    aw_addr_q;
    logic                 w_held;
    logic [DATA_W-1:0]    w_data_q;
    logic [3:0]           w_strb_q;

    logic                 aw_take;
    logic                 w_take;
    logic                 aw_have;
    logic                 w_have;
    logic                 do_write;
    logic [ADDR_W-1:0]    wr_addr;
    logic [DATA_W-1:0]    wr_data;
    logic [3:0]           wr_strb;
    gpm_reg_e             wr_sel;
    logic                 wr_ok;
    logic                 wr_low_byte;

    logic                 ar_take;
    gpm_reg_e             rd_sel;
    logic [DATA_W-1:0]    rd_word;
    logic [DATA_W-1:0]    status_word;

    // Write channel acceptance
    assign s_axi_awready = !aw_held && !s_axi_bvalid;
    assign s_axi_wready  = !w_held && !s_axi_bvalid;
    assign aw_take       = s_axi_awvalid && s_axi_awready;
    assign w_take        = s_axi_wvalid && s_axi_wready;
    assign aw_have       = aw_held || aw_take;
    assign w_have        = w_held || w_take;
    assign do_write      = aw_have && w_have && !s_axi_bvalid;
    assign wr_addr       = aw_held ? aw_addr_q : s_axi_awaddr;
    assign wr_data       = w_held ? w_data_q : s_axi_wdata;
    assign wr_strb       = w_held ? w_strb_q : s_axi_wstrb;
    assign wr_sel        = decode_reg(wr_addr);
    assign wr_ok         = (wr_sel != REG_NONE) && (wr_sel != REG_STATUS);
    assign wr_low_byte   = do_write && wr_strb[0];

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_held   <= 1'b0;
            aw_addr_q <= '0;
        end else if (do_write) begin
            aw_held   <= 1'b0;
        end else if (aw_take) begin
            aw_held   <= 1'b1;
            aw_addr_q <= s_axi_awaddr;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            w_held   <= 1'b0;
            w_data_q <= '0;
            w_strb_q <= '0;
        end else if (do_write) begin
            w_held   <= 1'b0;
        end else if (w_take) begin
            w_held   <= 1'b1;
            w_data_q <= s_axi_wdata;
            w_strb_q <= s_axi_wstrb;
        end
    end

    // Write response
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp  <= RESP_OKAY;
        end else if (do_write) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= wr_ok ? RESP_OKAY : RESP_SLVERR;
        end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ctl[0] <= CTL_RESET;
            ctl[1] <= CTL_RESET;
        end else if (wr_low_byte && wr_sel == REG_PIN1) begin
            ctl[0] <= wr_data[CTL_W-1:0];
        end else if (wr_low_byte && wr_sel == REG_PIN2) begin
            ctl[1] <= wr_data[CTL_W-1:0];
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            pin_input_enable <= INPUT_EN_RESET;
        end else if (wr_low_byte && wr_sel == REG_INEN) begin
            pin_input_enable <= wr_data[PIN_COUNT-1:0];
        end
    end

    // Read channel
    assign s_axi_arready = !s_axi_rvalid;
    assign ar_take       = s_axi_arvalid && s_axi_arready;
    assign rd_sel        = decode_reg(s_axi_araddr);
    assign status_word   = {26'h0, pin_oe, pin_out, pin_input_data};
    assign rd_word = (rd_sel == REG_PIN1)   ? {24'h0, ctl[0]} :
                     (rd_sel == REG_PIN2)   ? {24'h0, ctl[1]} :
                     (rd_sel == REG_INEN)   ? {30'h0, pin_input_enable} :
                     (rd_sel == REG_STATUS) ? status_word : 32'h0;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata  <= '0;
            s_axi_rresp  <= RESP_OKAY;
        end else if (ar_take) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata  <= rd_word;
            s_axi_rresp  <= (rd_sel == REG_NONE) ? RESP_SLVERR : RESP_OKAY;
        end else if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end

    // Input path
    gpm_sync u_sync (
        .aclk     (aclk),
        .aresetn  (aresetn),
        .async_in (pin_in),
        .sync_out (pin_in_sync)
    );

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            pin_input_data <= '0;
        end else begin
            pin_input_data <= pin_in_sync & pin_input_enable;
        end
    end

    // Output multiplexer per pin
    for (genvar k = 0; k < PIN_COUNT; k++) begin : g_pin
        gpm_out_mux u_mux (
            .src              (ctl[k][CTL_SRC_MSB:CTL_SRC_LSB]),
            .sel              (ctl[k][CTL_SEL_MSB:CTL_SEL_LSB]),
            .sw_value         (ctl[k][CTL_VAL_BIT]),
            .rx_remote_gpio   (rx_remote_gpio),
            .rx_lock          (rx_lock),
            .rx_pass          (rx_pass),
            .rx_frame_valid   (rx_frame_valid),
            .rx_line_valid    (rx_line_valid),
            .rx_port_enable   (rx_port_enable),
            .frame_sync_pulse (frame_sync_pulse),
            .tx_rx_select     (tx_rx_select),
            .tx_frame_valid   (tx_frame_valid),
            .tx_line_valid    (tx_line_valid),
            .tx_synchronized  (tx_synchronized),
            .tx_interrupt     (tx_interrupt),
            .level            (mux_level[k])
        );

        always_ff @(posedge aclk) begin
            if (!aresetn) begin
                pin_out[k] <= 1'b0;
                pin_oe[k]  <= 1'b0;
            end else begin
                pin_out[k] <= mux_level[k];
                pin_oe[k]  <= ctl[k][CTL_EN_BIT];
            end
        end
    end

    // Checks on pin one
    logic [2:0] p_src;
    logic [2:0] p_sel;
    assign p_src = ctl[0][CTL_SRC_MSB:CTL_SRC_LSB];
    assign p_sel = ctl[0][CTL_SEL_MSB:CTL_SEL_LSB];

    default clocking cb @(posedge aclk);
    endclocking
    default disable iff (!aresetn);

    rx_gpio_sel_a: assert property (
        !p_src[2] && !p_sel[2] |=> pin_out[0] == $past(rx_remote_gpio[{p_src[1:0], p_sel[1:0]}]))
        else $error("pin does not follow remote signal");

    rx_lock_pass_a: assert property (
        !p_src[2] && p_sel[2:1] == 2'b10
        |=> pin_out[0] == $past(p_sel[0] ? rx_pass[p_src[1:0]] : rx_lock[p_src[1:0]]))
        else $error("pin does not follow port lock or pass");

    rx_frame_sel_a: assert property (
        !p_src[2] && p_sel == SEL_RX_FRAME |=> pin_out[0] == $past(rx_frame_valid[p_src[1:0]]))
        else $error("pin does not follow frame valid");

    rx_line_sel_a: assert property (
        !p_src[2] && p_sel == SEL_RX_LINE |=> pin_out[0] == $past(rx_line_valid[p_src[1:0]]))
        else $error("pin does not follow line valid");

    dev_value_sel_a: assert property (
        p_src == SRC_DEVICE && p_sel == SEL_DEV_SW |=> pin_out[0] == $past(ctl[0][CTL_VAL_BIT]))
        else $error("pin does not show software value");

    dev_lock_or_a: assert property (
        p_src == SRC_DEVICE && p_sel == SEL_DEV_LOCK_OR
        |=> pin_out[0] == $past(|(rx_lock & rx_port_enable)))
        else $error("lock OR wrong");

    dev_pass_and_a: assert property (
        p_src == SRC_DEVICE && p_sel == SEL_DEV_PASS_AND && rx_port_enable != 4'h0
        |=> pin_out[0] == $past(&(rx_pass | ~rx_port_enable)))
        else $error("pass AND wrong");

    dev_sync_sel_a: assert property (
        p_src == SRC_DEVICE && p_sel == SEL_DEV_FRAME_SYNC
        |=> pin_out[0] == $past(frame_sync_pulse))
        else $error("frame sync not routed");

    reserved_low_a: assert property (
        (p_src == SRC_RESERVED) || (p_src == SRC_DEVICE && p_sel[2])
        ##1 (p_src == SRC_RESERVED) || (p_src == SRC_DEVICE && p_sel[2]) |-> !pin_out[0])
        else $error("reserved code drives pin high");

    tx_frame_sel_a: assert property (
        p_src == SRC_TX1 && p_sel == SEL_TX_FRAME |=> pin_out[0] == $past(tx_frame_valid[1]))
        else $error("transmit frame valid wrong");

    tx_pass_and_a: assert property (
        p_src == SRC_TX0 && p_sel == SEL_TX_PASS_AND && tx_rx_select[3:0] != 4'h0
        |=> pin_out[0] == $past(&(rx_pass | ~tx_rx_select[3:0])))
        else $error("transmit pass AND wrong");

    tx_pass_or_a: assert property (
        p_src == SRC_TX0 && p_sel == SEL_TX_PASS_OR
        |=> pin_out[0] == $past(|(rx_pass & tx_rx_select[3:0])))
        else $error("transmit pass OR wrong");

    tx_sync_sel_a: assert property (
        p_src == SRC_TX0 && p_sel == SEL_TX_SYNC |=> pin_out[0] == $past(tx_synchronized[0]))
        else $error("synchronized flag not routed");

    tx_irq_sel_a: assert property (
        p_src == SRC_TX1 && p_sel == SEL_TX_IRQ |=> pin_out[0] == $past(tx_interrupt[1]))
        else $error("transmit interrupt not routed");

    drive_on_a: assert property (
        ctl[0][CTL_EN_BIT] |=> pin_oe[0])
        else $error("driver off while enabled");

    drive_off_a: assert property (
        !ctl[0][CTL_EN_BIT] [*2] |-> !pin_oe[0])
        else $error("driver on while disabled");

    reset_clear_a: assert property (disable iff (1'b0)
        !aresetn |=> ctl[0] == CTL_RESET && pin_oe == 2'h0 && pin_input_enable == INPUT_EN_RESET)
        else $error("reset values wrong");

    write_resp_a: assert property (
        do_write |=> s_axi_bvalid && !s_axi_awready && !s_axi_wready)
        else $error("write response missing");

    read_resp_a: assert property (
        ar_take |=> s_axi_rvalid && !s_axi_arready)
        else $error("read response missing");

    pin1_write_c: cover property (do_write && wr_sel == REG_PIN1 ##2 pin_oe[0]);
    tx_sync_c:    cover property (p_src == SRC_TX0 && p_sel == SEL_TX_SYNC ##1 pin_out[0]);
    read_err_c:   cover property (s_axi_rvalid && s_axi_rresp == RESP_SLVERR);

endmodule : gpm_pin_ctrl
`default_nettype wire

//--- rtl/gpm_pkg.sv
// Constants and types shared by the pin output multiplexer files
package gpm_pkg;

    localparam int PIN_COUNT = 2;
    localparam int RX_PORTS  = 4;
    localparam int TX_PORTS  = 2;
    localparam int ADDR_W    = 8;
    localparam int DATA_W    = 32;

    // Control register fields
    localparam int CTL_W       = 8;
    localparam int CTL_EN_BIT  = 0;
    localparam int CTL_VAL_BIT = 1;
    localparam int CTL_SRC_LSB = 2;
    localparam int CTL_SRC_MSB = 4;
    localparam int CTL_SEL_LSB = 5;
    localparam int CTL_SEL_MSB = 7;

    // Values after reset
    localparam logic [CTL_W-1:0]     CTL_RESET      = 8'h00;
    localparam logic [PIN_COUNT-1:0] INPUT_EN_RESET = 2'h3;

    // Register indexes, byte address is four times the index
    localparam logic [ADDR_W-1:0] IDX_INPUT_EN   = 8'h0E;
    localparam logic [ADDR_W-1:0] IDX_PIN_STATUS = 8'h0F;
    localparam logic [ADDR_W-1:0] IDX_PIN1_CTL   = 8'h11;
    localparam logic [ADDR_W-1:0] IDX_PIN2_CTL   = 8'h12;

    // Source group codes
    localparam logic [2:0] SRC_DEVICE   = 3'h4;
    localparam logic [2:0] SRC_RESERVED = 3'h5;
    localparam logic [2:0] SRC_TX0      = 3'h6;
    localparam logic [2:0] SRC_TX1      = 3'h7;

    // Select codes, receive port group
    localparam logic [2:0] SEL_RX_LOCK  = 3'h4;
    localparam logic [2:0] SEL_RX_PASS  = 3'h5;
    localparam logic [2:0] SEL_RX_FRAME = 3'h6;
    localparam logic [2:0] SEL_RX_LINE  = 3'h7;

    // Select codes, device status group
    localparam logic [2:0] SEL_DEV_SW         = 3'h0;
    localparam logic [2:0] SEL_DEV_LOCK_OR    = 3'h1;
    localparam logic [2:0] SEL_DEV_PASS_AND   = 3'h2;
    localparam logic [2:0] SEL_DEV_FRAME_SYNC = 3'h3;

    // Select codes, transmit port group
    localparam logic [2:0] SEL_TX_PASS_AND = 3'h0;
    localparam logic [2:0] SEL_TX_PASS_OR  = 3'h1;
    localparam logic [2:0] SEL_TX_FRAME    = 3'h2;
    localparam logic [2:0] SEL_TX_LINE     = 3'h3;
    localparam logic [2:0] SEL_TX_SYNC     = 3'h4;
    localparam logic [2:0] SEL_TX_IRQ      = 3'h5;

    // Bus responses
    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef enum logic [2:0] {
        REG_NONE   = 3'b000,
        REG_PIN1   = 3'b001,
        REG_PIN2   = 3'b010,
        REG_INEN   = 3'b011,
        REG_STATUS = 3'b100
    } gpm_reg_e;

endpackage : gpm_pkg

//--- rtl/gpm_sync.sv
// Two flip-flop synchroniser for the pin inputs
`timescale 1ns/1ns
`default_nettype none
module gpm_sync
    import gpm_pkg::*;
(
    input  wire logic                 aclk,
    input  wire logic                 aresetn,
    input  wire logic [PIN_COUNT-1:0] async_in,
    output logic      [PIN_COUNT-1:0] sync_out
);

    logic [PIN_COUNT-1:0] meta;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            meta     <= '0;
            sync_out <= '0;
        end else begin
            meta     <= async_in;
            sync_out <= meta;
        end
    end

endmodule : gpm_sync
`default_nettype wire

//--- verification/gpio_pin_output_mux_tb.sv
// Self-checking bench for the pin output multiplexer
`timescale 1ns/1ns
`default_nettype none
`define CHK(g, e) begin checked++; if ((g) !== (e)) begin n_errors++; \
    $display("ERROR %0t got %h exp %h", $time, g, e); end end
module gpio_pin_output_mux_tb
    import gpm_pkg::*;
;
    localparam logic [52:0] PAT = 53'h1A5C396E15A3CB;
    logic        aclk = 0, aresetn = 0;
    logic [7:0]  awaddr = 0, araddr = 0;
    logic [31:0] wdata = 0, rdata, rd;
    logic [3:0]  wstrb = 0;
    logic        awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
    logic        awready, wready, bvalid, arready, rvalid;
    logic [1:0]  bresp, rresp, rsp;
    logic [15:0] remote = 0;
    logic [3:0]  lock = 0, pass = 0, fv = 0, lv = 0, pen = 0;
    logic        fs = 0;
    logic [7:0]  txsel = 0;
    logic [1:0]  tfv = 0, tlv = 0, tsy = 0, tirq = 0;
    logic [1:0]  ext_val = 0, ext_en = 0, pin_lvl, pout, poe, pdata;
    int          n_errors = 0, checked = 0, cyc = 0;

    gpm_pin_ctrl uut (.aclk(aclk), .aresetn(aresetn),
        .s_axi_awaddr(awaddr), .s_axi_awprot(3'h0), .s_axi_awvalid(awvalid),
        .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
        .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
        .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
        .s_axi_arprot(3'h0), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
        .s_axi_rready(rready), .rx_remote_gpio(remote), .rx_lock(lock),
        .rx_pass(pass), .rx_frame_valid(fv), .rx_line_valid(lv),
        .rx_port_enable(pen), .frame_sync_pulse(fs), .tx_rx_select(txsel),
        .tx_frame_valid(tfv), .tx_line_valid(tlv), .tx_synchronized(tsy),
        .tx_interrupt(tirq), .pin_in(pin_lvl), .pin_out(pout), .pin_oe(poe),
        .pin_input_data(pdata));

    gpm_pin_partner board (.pin_out(pout), .pin_oe(poe), .ext_val(ext_val),
        .ext_en(ext_en), .pin_level(pin_lvl));

    always #2 aclk = ~aclk;

    // Expected pin level for a source group and select code
    function automatic logic expect_pin(input logic [2:0] s, input logic [2:0] k,
                                        input logic v);
        logic [3:0] m;
        logic [7:0] rxv;
        m   = txsel[4*s[0] +: 4];
        rxv = {lv[s[1:0]], fv[s[1:0]], pass[s[1:0]], lock[s[1:0]], remote[4*s[1:0] +: 4]};
        case (s)
            3'h4: case (k)
                3'h0: return v;
                3'h1: return |(lock & pen);
                3'h2: return (pen != 4'h0) && &(pass | ~pen);
                3'h3: return fs;
                default: return 1'b0;
            endcase
            3'h5: return 1'b0;
            3'h6, 3'h7: case (k)
                3'h0: return (m != 4'h0) && &(pass | ~m);
                3'h1: return |(pass & m);
                3'h2: return tfv[s[0]];
                3'h3: return tlv[s[0]];
                3'h4: return tsy[s[0]];
                3'h5: return tirq[s[0]];
                default: return 1'b0;
            endcase
            default: return rxv[k];
        endcase
    endfunction : expect_pin

    task automatic axw(input logic [7:0] a, input logic [31:0] d,
                       input logic [3:0] s, output logic [1:0] r);
        @(posedge aclk);
        awaddr  <= a;
        wdata   <= d;
        wstrb   <= s;
        awvalid <= 1'b1;
        wvalid  <= 1'b1;
        bready  <= 1'b1;
        do begin
            @(posedge aclk);
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
        end while (!bvalid);
        r = bresp;
        bready <= 1'b0;
    endtask : axw

    task automatic axr(input logic [7:0] a, output logic [31:0] d,
                       output logic [1:0] r);
        @(posedge aclk);
        araddr  <= a;
        arvalid <= 1'b1;
        rready  <= 1'b1;
        do begin
            @(posedge aclk);
            if (arready) arvalid <= 1'b0;
        end while (!rvalid);
        d = rdata;
        r = rresp;
        rready <= 1'b0;
    endtask : axr

    task automatic complete_run;
        $display("checks %0d errors %0d", checked, n_errors);
        if (n_errors == 0 && checked > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask : complete_run

    always @(posedge aclk) begin
        cyc++;
        if (cyc == 20000) begin
            n_errors++;
            complete_run();
        end
    end

    initial begin
        repeat (6) @(posedge aclk);
        aresetn <= 1'b1;
        axr(8'h44, rd, rsp);
        `CHK(rd, 32'h0)
        `CHK(poe, 2'h0)
        axr(8'h38, rd, rsp);
        `CHK(rd, 32'h3)
        axr(8'h80, rd, rsp);
        `CHK(rsp, RESP_SLVERR)
        for (int k = 0; k < 2; k++) begin
            @(posedge aclk);
            {remote, lock, pass, fv, lv, pen, fs, txsel, tfv, tlv, tsy, tirq}
                <= PAT ^ {53{k[0]}};
            for (int c = 0; c < 64; c++) begin
                axw(8'h44, {24'h0, c[5:0], k[0], 1'b1}, 4'hF, rsp);
                repeat (2) @(posedge aclk);
                `CHK(poe[0], 1'b1)
                `CHK(pout[0], expect_pin(c[2:0], c[5:3], k[0]))
            end
        end
        axw(8'h44, 32'h12, 4'hF, rsp);
        repeat (2) @(posedge aclk);
        `CHK(poe[0], 1'b0)
        axw(8'h44, 32'hFF, 4'hE, rsp);
        axr(8'h44, rd, rsp);
        `CHK(rd, 32'h12)
        axw(8'h3C, 32'hFF, 4'hF, rsp);
        `CHK(rsp, RESP_SLVERR)
        axw(8'h48, 32'hA5, 4'hF, rsp);
        axr(8'h48, rd, rsp);
        `CHK(rd, 32'hA5)
        `CHK(poe[1], 1'b1)
        `CHK(pout[1], expect_pin(3'h1, 3'h5, 1'b0))
        axw(8'h48, 32'h0, 4'hF, rsp);
        @(posedge aclk);
        ext_en  <= 2'h3;
        ext_val <= 2'h1;
        repeat (4) @(posedge aclk);
        `CHK(pdata, 2'h1)
        axw(8'h38, 32'h0, 4'hF, rsp);
        repeat (4) @(posedge aclk);
        `CHK(pdata, 2'h0)
        aresetn <= 1'b0;
        repeat (3) @(posedge aclk);
        aresetn <= 1'b1;
        axr(8'h44, rd, rsp);
        `CHK(rd, 32'h0)
        axr(8'h38, rd, rsp);
        `CHK(rd, 32'h3)
        complete_run();
    end
endmodule : gpio_pin_output_mux_tb
`default_nettype wire

//--- verification/gpm_pin_partner.sv
// Board side of the two pins: device drive, board drive or pull-up
`timescale 1ns/1ns
`default_nettype none
module gpm_pin_partner
    import gpm_pkg::*;
(
    input  wire logic [PIN_COUNT-1:0] pin_out,
    input  wire logic [PIN_COUNT-1:0] pin_oe,
    input  wire logic [PIN_COUNT-1:0] ext_val,
    input  wire logic [PIN_COUNT-1:0] ext_en,
    output logic      [PIN_COUNT-1:0] pin_level
);
    // Device drive first, then board, else pull-up
    assign pin_level = (pin_oe & pin_out) | (~pin_oe & ext_en & ext_val)
                     | (~pin_oe & ~ext_en);
endmodule : gpm_pin_partner
`default_nettype wire
